//--- uwt_map.svh
`ifndef UWT_MAP_SVH
`define UWT_MAP_SVH
// Register byte offsets
`define UWT_ADDR_SERIAL_CONTROL  8'h00
`define UWT_ADDR_TX_DATA         8'h04
`define UWT_ADDR_RX_BUFFER       8'h08
`define UWT_ADDR_TIMER_CONTROL   8'h0c
`define UWT_ADDR_COUNTER         8'h10
`define UWT_ADDR_CAPTURE_RELOAD  8'h14
// Serial control fields
`define UWT_SC_MODE_BIT0    0
`define UWT_SC_MODE_BIT1    1
`define UWT_SC_DOUBLING     2
`define UWT_SC_TX_BAUD_SEL  3
`define UWT_SC_RX_BAUD_SEL  4
`define UWT_SC_RX_ENABLE    5
`define UWT_SC_TX_DONE      6
`define UWT_SC_RX_DONE      7
`define UWT_SC_RX_BIT8      8
`define UWT_SC_TX_BIT8      9
`define UWT_SC_TX_BUSY      10
// Reload timer control fields
`define UWT_TC_RUN          0
`define UWT_TC_CAPTURE_SEL  1
`define UWT_TC_EXT_ENABLE   2
`define UWT_TC_DIR_ENABLE   3
`define UWT_TC_OVF_FLAG     4
`define UWT_TC_EXT_FLAG     5
`define UWT_TC_COUNT_PIN    6
// Reset values and counts
`define UWT_SC_RESET        6'h00
`define UWT_TC_RESET        4'h0
`define UWT_COUNT_RESET     16'h0000
`define UWT_COUNT_MAX       16'hffff
`define UWT_DIV_TIMER       4'hb
`define UWT_SUB_LAST        4'hf
`define UWT_SUB_MID         4'h7
`define UWT_BITS_MODE1      4'h9
`define UWT_BITS_MODE9      4'ha
`define UWT_DATA_MODE1      4'h7
`define UWT_DATA_MODE9      4'h8
`endif

//--- uwt_partner.sv
`timescale 1ns/1ns
module uwt_partner (
  input  wire logic mclk,
  input  wire logic txd,
  output logic      rxd
);
  int         bitClk = 32;
  int         nBits  = 9;
  logic [8:0] got;
  logic       gotStop;

  // Line rests high between frames, as a pulled-up idle line would
  initial rxd = 1'b1;

  task automatic send(input logic [8:0] d);
    for (int i = -1; i <= nBits; i++)
    begin
      rxd <= (i < 0) ? 1'b0 : (i == nBits) ? 1'b1 : d[i];
      repeat (bitClk) @(posedge mclk);
    end
  endtask

  // Mid-bit sampling only; short glitches are not filtered out
  always
  begin
    @(negedge txd);
    repeat (bitClk / 2) @(posedge mclk);
    for (int i = 0; i < nBits; i++)
    begin
      repeat (bitClk) @(posedge mclk);
      got[i] = txd;
    end
    repeat (bitClk) @(posedge mclk);
    gotStop = txd;
  end
endmodule

//--- uwt_pkg.sv
package uwt_pkg;
  typedef enum logic [1:0] {RX_IDLE, RX_START, RX_DATA, RX_STOP} uwt_rx_state_type;
  typedef logic [1:0] uwt_mode_type;
endpackage

//--- uwt_testbench.sv
`timescale 1ns/1ns
module testbench;
  typedef struct {logic [15:0] sc; logic [8:0] d; int bc;} uwt_row_type;
  logic        mclk = 1'b0;
  logic        rst_b = 1'b0;
  logic        cyc = 1'b0;
  logic        stb = 1'b0;
  logic        we = 1'b0;
  logic        trig = 1'b1;
  logic        t1 = 1'b0;
  logic        cp = 1'b1;
  logic        txd, rxd, ack, ovf;
  logic [7:0]  adr = 8'h00;
  logic [31:0] dw = 32'h0;
  logic [31:0] dr, q;
  int          numErrors = 0;
  int          cmpCount = 0;
  uwt_row_type rows [4] = '{'{16'h0025, 9'h0a5, 32}, '{16'h0222, 9'h13c, 64},
                            '{16'h023f, 9'h1c3, 32}, '{16'h0026, 9'h05a, 32}};

  always #5 mclk = ~mclk;
  // Timer 1 stand-in: a one-cycle pulse every second clock
  always @(posedge mclk) t1 <= ~t1;
  // Count pin stand-in: falls once every 24 clocks, the fastest rate the timer accepts
  always
  begin
    repeat (12) @(posedge mclk);
    cp <= ~cp;
  end

  uwt_uart_timer dut_u (
    .mclk(mclk), .rst_b(rst_b), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
    .wb_adr_i(adr), .wb_sel_i(4'hf), .wb_dat_i(dw), .wb_dat_o(dr), .wb_ack_o(ack),
    .rxd(rxd), .txd(txd), .external_trigger_pin(trig), .external_count_pin(cp),
    .timer1Overflow(t1), .reloadTimerOverflow(ovf)
  );
  uwt_partner far_u (.mclk(mclk), .txd(txd), .rxd(rxd));

  task automatic closeOut();
    $display("errors %0d comparisons %0d", numErrors, cmpCount);
    if (numErrors == 0 && cmpCount > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    cmpCount++;
    if (g !== e)
    begin
      numErrors++;
      $display("unexpected at %0t: got %h expected %h", $time, g, e);
    end
  endtask

  // Entered just after a rising edge; leaves one idle cycle behind
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    dw <= d;
    do
    begin
      @(posedge mclk);
      n++;
    end
    while (ack !== 1'b1);
    q = dr;
    // Answer comes one cycle after the taking edge
    chk(n, 2);
    cyc <= 1'b0;
    stb <= 1'b0;
    @(posedge mclk);
  endtask

  // Cycles between two overflow pulses
  task automatic gap(output int n);
    n = 0;
    do @(posedge mclk); while (ovf !== 1'b1 && ++n < 99);
    n = 0;
    do
    begin
      @(posedge mclk);
      n++;
    end
    while (ovf !== 1'b1 && n < 99);
  endtask

  initial
  begin
    int n;
    logic [8:0] m;
    logic hi;
    logic [31:0] c1;
    repeat (12) @(posedge mclk);
    rst_b <= 1'b1;
    repeat (3) @(posedge mclk);
    chk(txd, 1'b1);
    wb(1'b0, 8'h00, 32'h0);
    chk(q, 32'h0);
    wb(1'b0, 8'h0c, 32'h0);
    chk(q, 32'h0);
    wb(1'b0, 8'h1c, 32'h0);
    chk(q, 32'h0);
    wb(1'b1, 8'h14, 32'hffff);
    wb(1'b1, 8'h10, 32'hfff0);
    wb(1'b1, 8'h0c, 32'h1);
    foreach (rows[i])
    begin
      far_u.bitClk = rows[i].bc;
      far_u.nBits = (rows[i].sc[1:0] == 2'b01) ? 8 : 9;
      m = (far_u.nBits == 8) ? 9'h0ff : 9'h1ff;
      wb(1'b1, 8'h00, rows[i].sc);
      fork
        wb(1'b1, 8'h04, rows[i].d);
        far_u.send(~rows[i].d);
      join
      n = 0;
      do
      begin
        wb(1'b0, 8'h00, 32'h0);
        n++;
      end
      while (q[7:6] !== 2'b11 && n < 500);
      chk(q[7:6], 2'b11);
      chk(far_u.got & m, rows[i].d & m);
      chk(far_u.gotStop, 1'b1);
      wb(1'b0, 8'h08, 32'h0);
      chk(q[8:0] & m, ~rows[i].d & m);
      wb(1'b1, 8'h00, rows[i].sc | 16'h00c0);
    end
    far_u.send(9'h0c3);
    fork
      far_u.send(9'h13e);
      begin
        repeat (100) @(posedge mclk);
        wb(1'b0, 8'h08, 32'h0);
        chk(q[8:0], 9'h0c3);
      end
    join
    repeat (40) @(posedge mclk);
    wb(1'b0, 8'h08, 32'h0);
    chk(q[8:0], 9'h13e);
    wb(1'b1, 8'h00, 32'h20);
    wb(1'b1, 8'h04, 32'h55);
    hi = 1'b1;
    repeat (40)
    begin
      @(posedge mclk);
      hi &= txd;
    end
    chk(hi, 1'b1);
    wb(1'b1, 8'h14, 32'hfffe);
    wb(1'b1, 8'h10, 32'hfffe);
    wb(1'b1, 8'h0c, 32'h11);
    gap(n);
    chk(n, 24);
    wb(1'b0, 8'h10, 32'h0);
    chk(q[15:0], 16'hfffe);
    wb(1'b0, 8'h0c, 32'h0);
    chk(q[4], 1'b1);
    wb(1'b1, 8'h14, 32'hffff);
    wb(1'b1, 8'h0c, 32'h41);
    gap(n);
    chk(n, 24);
    wb(1'b1, 8'h0c, 32'h5);
    wb(1'b1, 8'h10, 32'h0100);
    trig <= 1'b0;
    repeat (4) @(posedge mclk);
    wb(1'b0, 8'h10, 32'h0);
    chk(q[15:1], 15'h7fff);
    trig <= 1'b1;
    wb(1'b1, 8'h0c, 32'h7);
    wb(1'b1, 8'h10, 32'h4000);
    trig <= 1'b0;
    repeat (4) @(posedge mclk);
    trig <= 1'b1;
    wb(1'b0, 8'h14, 32'h0);
    chk(q[15:1], 15'h2000);
    wb(1'b1, 8'h0c, 32'h9);
    trig <= 1'b0;
    wb(1'b1, 8'h10, 32'h0010);
    repeat (60) @(posedge mclk);
    wb(1'b0, 8'h10, 32'h0);
    chk(q[15:0] < 16'h0010, 1'b1);
    trig <= 1'b1;
    repeat (120) @(posedge mclk);
    wb(1'b0, 8'h10, 32'h0);
    chk(q[15:0] > 16'h0010, 1'b1);
    wb(1'b1, 8'h0c, 32'h0);
    wb(1'b0, 8'h10, 32'h0);
    c1 = q;
    repeat (50) @(posedge mclk);
    wb(1'b0, 8'h10, 32'h0);
    chk(q, c1);
    wb(1'b1, 8'h00, 32'h08);
    wb(1'b1, 8'h14, 32'hffff);
    wb(1'b1, 8'h10, 32'hfff0);
    wb(1'b1, 8'h0c, 32'h31);
    gap(n);
    chk(n, 2);
    wb(1'b0, 8'h0c, 32'h0);
    chk(q[4], 1'b0);
    wb(1'b1, 8'h0c, 32'h5);
    trig <= 1'b0;
    repeat (4) @(posedge mclk);
    wb(1'b0, 8'h0c, 32'h0);
    chk(q[5], 1'b1);
    rst_b <= 1'b0;
    repeat (2) @(posedge mclk);
    rst_b <= 1'b1;
    repeat (3) @(posedge mclk);
    chk(txd, 1'b1);
    wb(1'b0, 8'h0c, 32'h0);
    chk(q, 32'h0);
    wb(1'b0, 8'h10, 32'h0);
    chk(q, 32'h0);
    closeOut();
  end

  // Whole run needs under 8000 cycles
  initial
  begin
    repeat (20000) @(posedge mclk);
    numErrors++;
    closeOut();
  end
endmodule

//--- uwt_uart_timer.sv
// Summary of operation
// - Reload timer is a 16-bit up/down counter split into high and low bytes; here it is one 16-bit register at one offset.
// - Baud select set means baud generator; else capture or auto-reload; run clear stops.
// - Auto-reload reloads on overflow, and on trigger-pin falling edge when enabled.
// - Capture mode counts up; trigger falling edge copies count into capture register.
// - Reload and capture count at clock/12; count pin limited to clock/24.
// - Baud generator counts at clock/2, no overflow flag; trigger edge sets extra flag.
// - Transmitter and receiver run at the same time, independently.
// - A received byte is buffered while the next one is being received.
// - Mode bits: 00 reserved, 01/10/11 select modes 1, 2 and 3.
// - Mode 1 uses 10-bit frames with 8 data bits, variable rate.
// - Mode 2 uses 11-bit frames with 9 data bits.
// - Mode 3 uses the 11-bit frame with timer-derived baud rate.
// - Baud clock is 16 times bit rate; divided by 16 internally.
// - Modes 1 and 3 pick transmit and receive baud sources separately.
// - Baud select 0: Timer 1 overflow times 2^doubling over 32.
// - Baud select 1: reload timer overflow times 2^doubling over 32.
// - Mode 2 bit rate is clock/64, or clock/32 with doubling set.
//
// Added by the designer: register access over Wishbone and the placing of the registers.
`timescale 1ns/1ns
`include "uwt_map.svh"
module uwt_uart_timer (
  input  wire logic        mclk,
  input  wire logic        rst_b,
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [7:0]  wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic      [31:0] wb_dat_o,
  output logic             wb_ack_o,
  input  wire logic        rxd,
  output logic             txd,
  input  wire logic        external_trigger_pin,
  input  wire logic        external_count_pin,
  input  wire logic        timer1Overflow,
  output logic             reloadTimerOverflow
);
  import uwt_pkg::*;

  logic [1:0]  rstSync_reg;
  logic        rstN;
  always_ff @(posedge mclk or negedge rst_b)
  begin
    if (!rst_b)
      rstSync_reg <= 2'b00;
    else
      rstSync_reg <= {rstSync_reg[0], 1'b1};
  end
  assign rstN = rstSync_reg[1];

  // Bus access decode
  logic        busReq;
  logic        busWr;
  assign busReq = wb_cyc_i & wb_stb_i & ~wb_ack_o;
  assign busWr  = busReq & wb_we_i & wb_sel_i[0];

  function automatic logic hit(input logic [7:0] adr, input logic [7:0] off);
    hit = (adr == off);
  endfunction

  // Configuration and flags
  logic [5:0]  sc_reg, sc_next;
  logic [3:0]  tc_reg, tc_next;
  logic        txDone_reg, txDone_next, rxDone_reg, rxDone_next;
  logic        ovfFlag_reg, ovfFlag_next, extFlag_reg, extFlag_next;
  logic [15:0] count_reg, count_next, reload_reg, reload_next;
  logic [3:0]  pre_reg, pre_next;
  logic        trigPrev_reg, cntPinSample_reg, cntPinSample_next;
  logic        half_reg, half_next;
  logic [31:0] rdata_next;
  logic        ack_next;

  uwt_mode_type mode;
  logic        doubling, baudMode, txSel, rxSel, runBit, capSel, extEn, dirEn;
  assign mode     = {sc_reg[`UWT_SC_MODE_BIT1], sc_reg[`UWT_SC_MODE_BIT0]};
  assign doubling = sc_reg[`UWT_SC_DOUBLING];
  assign txSel    = sc_reg[`UWT_SC_TX_BAUD_SEL];
  assign rxSel    = sc_reg[`UWT_SC_RX_BAUD_SEL];
  assign baudMode = txSel | rxSel;
  assign runBit   = tc_reg[`UWT_TC_RUN];
  assign capSel   = tc_reg[`UWT_TC_CAPTURE_SEL];
  assign extEn    = tc_reg[`UWT_TC_EXT_ENABLE];
  assign dirEn    = tc_reg[`UWT_TC_DIR_ENABLE];

  // Count pin select lives in the timer control word above the flags
  logic        cntPinSel_reg, cntPinSel_next;

  // Timer tick sources
  logic        preTick, trigFall, pinFall, timerTick, up, ovf;
  assign preTick  = (pre_reg == `UWT_DIV_TIMER);
  assign trigFall = trigPrev_reg & ~external_trigger_pin;
  // Pin sampled once per twelve clocks, so a fall needs two samples: clock/24 at most
  assign pinFall  = preTick & cntPinSample_reg & ~external_count_pin;

  always_comb
  begin
    timerTick = 1'b0;
    up        = 1'b1;
    if (runBit)
    begin
      if (baudMode)
        timerTick = half_reg;
      else if (cntPinSel_reg)
        timerTick = pinFall;
      else
        timerTick = preTick;
      if (!baudMode && !capSel && dirEn)
        up = external_trigger_pin;
    end
  end

  assign ovf = timerTick & (up ? (count_reg == `UWT_COUNT_MAX) : (count_reg == reload_reg));
  assign reloadTimerOverflow = ovf;

  // Serial baud ticks, index 0 transmit, index 1 receive
  logic [1:0]  srcTick, tick16, halfDir_reg, halfDir_next;
  logic [1:0]  dirSel;
  assign dirSel = {rxSel, txSel};
  genvar d;
  generate
    for (d = 0; d < 2; d++)
    begin : g_baud
      always_comb
      begin
        if (mode == 2'b10)
          srcTick[d] = half_reg;
        else
          srcTick[d] = dirSel[d] ? ovf : timer1Overflow;
        halfDir_next[d] = halfDir_reg[d] ^ srcTick[d];
        tick16[d] = srcTick[d] & (doubling | halfDir_reg[d]);
      end
    end
  endgenerate

  // Transmitter
  logic [10:0] txShift_reg, txShift_next;
  logic [3:0]  txBits_reg, txBits_next, txSub_reg, txSub_next;
  logic        txBusy_reg, txBusy_next, txd_next, txBit8_reg, txBit8_next;
  logic        nineBit, txStart, txFrameEnd;
  assign nineBit = mode[1];
  assign txStart = busWr & hit(wb_adr_i, `UWT_ADDR_TX_DATA) & ~txBusy_reg & (mode != 2'b00);
  assign txFrameEnd = txBusy_reg & tick16[0] & (txSub_reg == `UWT_SUB_LAST)
                      & (txBits_reg == (nineBit ? `UWT_BITS_MODE9 : `UWT_BITS_MODE1));

  always_comb
  begin
    txShift_next = txShift_reg;
    txBits_next  = txBits_reg;
    txSub_next   = txSub_reg;
    txBusy_next  = txBusy_reg;
    txd_next     = txd;
    if (txStart)
    begin
      txShift_next = {1'b1, nineBit ? txBit8_reg : 1'b1, wb_dat_i[7:0], 1'b0};
      txBits_next  = 4'h0;
      txSub_next   = 4'h0;
      txBusy_next  = 1'b1;
      txd_next     = 1'b0;
    end
    else if (txBusy_reg && tick16[0])
    begin
      txSub_next = txSub_reg + 4'h1;
      if (txSub_reg == `UWT_SUB_LAST)
      begin
        txShift_next = {1'b1, txShift_reg[10:1]};
        txBits_next  = txBits_reg + 4'h1;
        txd_next     = txShift_reg[1];
        if (txFrameEnd)
        begin
          txBusy_next = 1'b0;
          txd_next    = 1'b1;
        end
      end
    end
  end

  // Receiver
  uwt_rx_state_type rxState_reg, rxState_next;
  logic [8:0]  rxShift_reg, rxShift_next, rxBuf_reg, rxBuf_next;
  logic [3:0]  rxSub_reg, rxSub_next, rxCnt_reg, rxCnt_next;
  logic        rxFrameDone;

  always_comb
  begin
    rxState_next = rxState_reg;
    rxShift_next = rxShift_reg;
    rxSub_next   = rxSub_reg;
    rxCnt_next   = rxCnt_reg;
    rxBuf_next   = rxBuf_reg;
    rxFrameDone  = 1'b0;
    if (mode == 2'b00 || !sc_reg[`UWT_SC_RX_ENABLE])
      rxState_next = RX_IDLE;
    else if (tick16[1])
    begin
      rxSub_next = rxSub_reg + 4'h1;
      case (rxState_reg)
        RX_IDLE:
        begin
          rxSub_next = 4'h0;
          if (!rxd)
            rxState_next = RX_START;
        end
        RX_START:
          if (rxSub_reg == `UWT_SUB_MID)
          begin
            // Centre sample rejects glitches shorter than half a bit
            rxState_next = rxd ? RX_IDLE : RX_DATA;
            rxSub_next   = 4'h0;
            rxCnt_next   = 4'h0;
          end
        RX_DATA:
          if (rxSub_reg == `UWT_SUB_LAST)
          begin
            rxShift_next = {rxd, rxShift_reg[8:1]};
            rxCnt_next   = rxCnt_reg + 4'h1;
            if (rxCnt_reg == (nineBit ? `UWT_DATA_MODE9 : `UWT_DATA_MODE1))
              rxState_next = RX_STOP;
          end
        RX_STOP:
          if (rxSub_reg == `UWT_SUB_LAST)
          begin
            rxState_next = RX_IDLE;
            if (rxd)
            begin
              // Buffer written only at frame end, so the previous byte stays readable
              rxBuf_next  = nineBit ? rxShift_reg : {rxd, rxShift_reg[8:1]};
              rxFrameDone = 1'b1;
            end
          end
        default:
          rxState_next = RX_IDLE;
      endcase
    end
  end

  // Timer, flags, configuration and bus answer
  always_comb
  begin
    sc_next = sc_reg;
    tc_next = tc_reg;
    cntPinSel_next = cntPinSel_reg;
    txBit8_next = txBit8_reg;
    count_next = count_reg;
    reload_next = reload_reg;
    pre_next = preTick ? 4'h0 : pre_reg + 4'h1;
    half_next = ~half_reg;
    cntPinSample_next = preTick ? external_count_pin : cntPinSample_reg;
    txDone_next = txDone_reg;
    rxDone_next = rxDone_reg;
    ovfFlag_next = ovfFlag_reg;
    extFlag_next = extFlag_reg;
    rdata_next = 32'h0;
    ack_next = busReq;
    if (busWr)
    begin
      if (hit(wb_adr_i, `UWT_ADDR_SERIAL_CONTROL))
      begin
        sc_next = wb_dat_i[5:0];
        txBit8_next = wb_dat_i[`UWT_SC_TX_BIT8];
        txDone_next = txDone_reg & ~wb_dat_i[`UWT_SC_TX_DONE];
        rxDone_next = rxDone_reg & ~wb_dat_i[`UWT_SC_RX_DONE];
      end
      else if (hit(wb_adr_i, `UWT_ADDR_TIMER_CONTROL))
      begin
        tc_next = wb_dat_i[3:0];
        cntPinSel_next = wb_dat_i[`UWT_TC_COUNT_PIN];
        ovfFlag_next = ovfFlag_reg & ~wb_dat_i[`UWT_TC_OVF_FLAG];
        extFlag_next = extFlag_reg & ~wb_dat_i[`UWT_TC_EXT_FLAG];
      end
      else if (hit(wb_adr_i, `UWT_ADDR_COUNTER))
        count_next = wb_dat_i[15:0];
      else if (hit(wb_adr_i, `UWT_ADDR_CAPTURE_RELOAD))
        reload_next = wb_dat_i[15:0];
    end
    // Hardware events after software clears: a set in the clear cycle wins
    if (txFrameEnd)
      txDone_next = 1'b1;
    if (rxFrameDone)
      rxDone_next = 1'b1;
    if (timerTick)
    begin
      if (ovf)
      begin
        count_next = up ? reload_reg : `UWT_COUNT_MAX;
        if (!baudMode)
          ovfFlag_next = 1'b1;
      end
      else
        count_next = up ? count_reg + 16'h1 : count_reg - 16'h1;
    end
    if (runBit && extEn && trigFall)
    begin
      extFlag_next = 1'b1;
      if (!baudMode && capSel)
        reload_next = count_reg;
      else if (!baudMode && !dirEn)
        count_next = reload_reg;
    end
    if (busReq && !wb_we_i)
    begin
      if (hit(wb_adr_i, `UWT_ADDR_SERIAL_CONTROL))
        rdata_next = {21'h0, txBusy_reg, txBit8_reg, rxBuf_reg[8], rxDone_reg, txDone_reg, sc_reg};
      else if (hit(wb_adr_i, `UWT_ADDR_TX_DATA))
        rdata_next = {31'h0, txBusy_reg};
      else if (hit(wb_adr_i, `UWT_ADDR_RX_BUFFER))
        rdata_next = {23'h0, rxBuf_reg};
      else if (hit(wb_adr_i, `UWT_ADDR_TIMER_CONTROL))
        rdata_next = {25'h0, cntPinSel_reg, extFlag_reg, ovfFlag_reg, tc_reg};
      else if (hit(wb_adr_i, `UWT_ADDR_COUNTER))
        rdata_next = {16'h0, count_reg};
      else if (hit(wb_adr_i, `UWT_ADDR_CAPTURE_RELOAD))
        rdata_next = {16'h0, reload_reg};
    end
  end

  always_ff @(posedge mclk or negedge rstN)
  begin
    if (!rstN)
    begin
      sc_reg <= `UWT_SC_RESET;
      tc_reg <= `UWT_TC_RESET;
      cntPinSel_reg <= 1'b0;
      txBit8_reg <= 1'b0;
      count_reg <= `UWT_COUNT_RESET;
      reload_reg <= `UWT_COUNT_RESET;
      pre_reg <= 4'h0;
      half_reg <= 1'b0;
      halfDir_reg <= 2'b00;
      trigPrev_reg <= 1'b1;
      cntPinSample_reg <= 1'b1;
      txDone_reg <= 1'b0;
      rxDone_reg <= 1'b0;
      ovfFlag_reg <= 1'b0;
      extFlag_reg <= 1'b0;
      wb_dat_o <= 32'h0;
      wb_ack_o <= 1'b0;
      txShift_reg <= 11'h7ff;
      txBits_reg <= 4'h0;
      txSub_reg <= 4'h0;
      txBusy_reg <= 1'b0;
      txd <= 1'b1;
      rxState_reg <= RX_IDLE;
      rxShift_reg <= 9'h0;
      rxSub_reg <= 4'h0;
      rxCnt_reg <= 4'h0;
      rxBuf_reg <= 9'h0;
    end
    else
    begin
      sc_reg <= sc_next;
      tc_reg <= tc_next;
      cntPinSel_reg <= cntPinSel_next;
      txBit8_reg <= txBit8_next;
      count_reg <= count_next;
      reload_reg <= reload_next;
      pre_reg <= pre_next;
      half_reg <= half_next;
      halfDir_reg <= halfDir_next;
      trigPrev_reg <= external_trigger_pin;
      cntPinSample_reg <= cntPinSample_next;
      txDone_reg <= txDone_next;
      rxDone_reg <= rxDone_next;
      ovfFlag_reg <= ovfFlag_next;
      extFlag_reg <= extFlag_next;
      wb_dat_o <= rdata_next;
      wb_ack_o <= ack_next;
      txShift_reg <= txShift_next;
      txBits_reg <= txBits_next;
      txSub_reg <= txSub_next;
      txBusy_reg <= txBusy_next;
      txd <= txd_next;
      rxState_reg <= rxState_next;
      rxShift_reg <= rxShift_next;
      rxSub_reg <= rxSub_next;
      rxCnt_reg <= rxCnt_next;
      rxBuf_reg <= rxBuf_next;
    end
  end
endmodule

//--- uwt_uart_timer_monitor.sv
`timescale 1ns/1ns
module uwt_uart_timer_monitor (
  input wire logic        mclk,
  input wire logic        rst_b,
  input wire logic        wb_cyc_i,
  input wire logic        wb_stb_i,
  input wire logic        wb_we_i,
  input wire logic [7:0]  wb_adr_i,
  input wire logic [3:0]  wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic        wb_ack_o,
  input wire logic        rxd,
  input wire logic        txd,
  input wire logic        external_trigger_pin,
  input wire logic        external_count_pin,
  input wire logic        timer1Overflow,
  input wire logic        reloadTimerOverflow
);
  logic req;
  logic mapped;
  assign req = wb_cyc_i && wb_stb_i && !wb_ack_o;
  assign mapped = wb_adr_i inside {8'h00, 8'h04, 8'h08, 8'h0c, 8'h10, 8'h14};

  default clocking @(posedge mclk); endclocking
  default disable iff (!rst_b);

  a_ack_follows: assert property (req |=> wb_ack_o)
    else $error("no ack after request");
  a_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack held too long");
  a_ack_only_req: assert property ($rose(wb_ack_o) |-> $past(req))
    else $error("ack without request");
  a_unmapped_zero: assert property (req && !mapped |=> wb_dat_o == 32'h0)
    else $error("unmapped read not zero");
  a_write_zero: assert property (req && wb_we_i |=> wb_dat_o == 32'h0)
    else $error("data out during write");
  a_rxbuf_width: assert property (
    req && !wb_we_i && wb_adr_i == 8'h08 |=> wb_dat_o[31:9] == 23'h0)
    else $error("receive buffer too wide");
  a_start_min: assert property ($fell(txd) |-> !txd [*8])
    else $error("serial bit too short");
  a_ovf_single: assert property (reloadTimerOverflow |=> !reloadTimerOverflow)
    else $error("overflow pulse too long");

  c_rx_read: cover property (req && !wb_we_i && wb_adr_i == 8'h08);
  c_overflow: cover property (reloadTimerOverflow);
  c_tx_start: cover property ($fell(txd));
endmodule

bind uwt_uart_timer uwt_uart_timer_monitor mon_u (
  .mclk(mclk), .rst_b(rst_b), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
  .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i),
  .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .rxd(rxd),
  .txd(txd), .external_trigger_pin(external_trigger_pin),
  .external_count_pin(external_count_pin), .timer1Overflow(timer1Overflow),
  .reloadTimerOverflow(reloadTimerOverflow)
);
